// >>> rac_cfg.svh
// register map, field positions, reset values and timing constants of the adapt/lock control
// Operation
// - slow-edge bit doubles output transition times; resets to zero for fastest edges
// - output inversion bit inverts serial output data of the selected channel only
// - default score is smaller of eye width and scaled eye height
// - feedback score type: 0 invalid, 1 width, 2 height, 3 both (reset)
// - linear score type field uses the same encoding as feedback score type
// - weighted score is (width-b)*a plus (height-c)*(1-a), factors from three registers
// - weighted score used for linear when bit 7 set, feedback when bit 6
// - rate and subrate bits form one four-bit code constraining the lock search
// - tuning mode: none, linear, linear-feedback-linear, linear-until-lock-feedback-linear; reset is 1
// - mode 0 adapts nothing; equalizer values come only from host settings
// - mode 1 adapts linear only; feedback enabled with all taps forced zero
// - feedback adaptation taps never exceed limits held in two limit registers
// - lock is declared only when width and height both exceed their thresholds
// - while locked, either eye opening at or below its threshold declares loss of lock
// - clearing the eye-monitor enable stops eye-based loss of lock
// - on unlock, restart acquisition, and adapt when tuning mode is nonzero
// - host sets then clears linear trigger; device starts one linear run
// - host sets then clears feedback trigger; device starts one feedback run
// - reference clock calibrates oscillator coarse tuning at reset, no sweep needed
// - reference clock detects oscillator drift quickly and raises loss-of-lock interrupt
// - lock to a jitter spur restarts adaptation and lock until correct rate
`ifndef RAC_CFG_SVH
`define RAC_CFG_SVH

// register offsets
`define RAC_A_SLEW 8'h18
`define RAC_A_POL 8'h1f
`define RAC_A_FBTRIG 8'h24
`define RAC_A_FBSCORE 8'h2c
`define RAC_A_RATE 8'h2f
`define RAC_A_MODE 8'h31
`define RAC_A_LIMA 8'h33
`define RAC_A_TAPLO 8'h34
`define RAC_A_TAPHI 8'h35
`define RAC_A_REFMODE 8'h36
`define RAC_A_EYEMON 8'h3e
`define RAC_A_EYETH 8'h6a
`define RAC_A_WA 8'h6b
`define RAC_A_WB 8'h6c
`define RAC_A_WC 8'h6d
`define RAC_A_WEN 8'h6e
`define RAC_A_CHSEL 8'hff

// storage index of each register
`define RAC_I_SLEW 4'h0
`define RAC_I_POL 4'h1
`define RAC_I_FBTRIG 4'h2
`define RAC_I_FBSCORE 4'h3
`define RAC_I_RATE 4'h4
`define RAC_I_MODE 4'h5
`define RAC_I_LIMA 4'h6
`define RAC_I_TAPLO 4'h7
`define RAC_I_TAPHI 4'h8
`define RAC_I_REFMODE 4'h9
`define RAC_I_EYEMON 4'ha
`define RAC_I_EYETH 4'hb
`define RAC_I_WA 4'hc
`define RAC_I_WB 4'hd
`define RAC_I_WC 4'he
`define RAC_I_WEN 4'hf

// field positions
`define RAC_B_SLOW 2
`define RAC_B_INV 7
`define RAC_B_FBTRIG 2
`define RAC_B_LINTRIG 0
`define RAC_B_MONEN 7
`define RAC_B_WLIN 7
`define RAC_B_WFB 6
`define RAC_F_FBSCORE 5:4
`define RAC_F_LINSCORE 4:3
`define RAC_F_MODE 6:5
`define RAC_F_RATE 7:4
`define RAC_F_SUBRATE 5:4
`define RAC_F_TH_W 7:4
`define RAC_F_TH_H 3:0
`define RAC_F_TAP1MAX 4:0
`define RAC_F_TAPNMAX 3:0

// reset values
`define RAC_R_FBSCORE 8'h32
`define RAC_R_MODE 8'h38
`define RAC_R_TAPLO 8'h0f
`define RAC_R_TAPHI 8'h1f
`define RAC_R_REFMODE 8'h30
`define RAC_R_EYEMON 8'h80
`define RAC_R_ZERO 8'h00
`define RAC_R_CHSEL 8'h00

// channel served by this block, as a bit of the channel select value
`define RAC_CHAN_BIT 0

// score scaling and weighting
`define RAC_VSCALE_NUM 10'd3
`define RAC_VSCALE_SHIFT 1
`define RAC_WEIGHT_ONE 18'sd256
`define RAC_WEIGHT_SHIFT 8

// reference clock measurement
`define RAC_MCLK_MHZ 200
`define RAC_REF_MHZ 25
`define RAC_REF_WIN 8'd64
`define RAC_FREQ_TOL 16'd4

`endif

// >>> rac_far_tx.sv
// far-end transmitter model feeding the input stream
`timescale 1ns/10ps
`default_nettype none
module rac_far_tx (
    input wire logic clk_in, rstn_in, go_in, ready_in,
    output logic [7:0] data_out,
    output logic valid_out
);
    logic [7:0] sent_q[$];
    // hold each word until taken; an idle line shows the inverse
    always @(posedge clk_in or negedge rstn_in)
        if (!rstn_in) {valid_out, data_out} <= '0;
        else if (!valid_out || ready_in) begin
            if (valid_out) sent_q.push_back(data_out);
            valid_out <= go_in;
            data_out <= go_in ? 8'($urandom) : ~data_out;
        end
endmodule
`default_nettype wire

// >>> rac_monitor.sv
// assertion checker on the adapt/lock control ports
`timescale 1ns/10ps
`default_nettype none
module rac_monitor (
    input wire logic mclk_in, rstn_in, reg_wr_in, phase_lock_in, eye_valid_in, eng_done_in,
    input wire logic [7:0] reg_addr_in, reg_wdata_in,
    input wire logic locked_out, lol_irq_out, score_valid_out, lin_run_out, fb_run_out, slow_edge_out,
    input wire logic [3:0] rate_code_out
);
    logic sel_q;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // channel select shadow: unselected writes are dropped
    always_ff @(posedge mclk_in or negedge rstn_in)
        if (!rstn_in) sel_q <= 1'b0;
        else if (reg_wr_in && reg_addr_in == 8'hff) sel_q <= reg_wdata_in[0];
    property p_slew; reg_wr_in && reg_addr_in == 8'h18 && sel_q |=> slow_edge_out == $past(reg_wdata_in[2]); endproperty
    a_slew: assert property (p_slew) else $error("slew");
    property p_rate; reg_wr_in && reg_addr_in == 8'h2f && sel_q |=> rate_code_out == $past(reg_wdata_in[7:4]); endproperty
    a_rate: assert property (p_rate) else $error("rate");
    property p_lock; $rose(locked_out) |-> $past(eye_valid_in && phase_lock_in); endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_irq; lol_irq_out |-> !locked_out && $past(locked_out); endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_phase; locked_out && !phase_lock_in |=> !locked_out; endproperty
    a_phase: assert property (p_phase) else $error("phase");
    property p_score; score_valid_out |-> $past(eye_valid_in && (lin_run_out || fb_run_out)); endproperty
    a_score: assert property (p_score) else $error("score");
    property p_fbend; fb_run_out && eng_done_in |-> ##[1:2] !fb_run_out; endproperty
    a_fbend: assert property (p_fbend) else $error("fb run");
    property p_one; !(lin_run_out && fb_run_out); endproperty
    a_one: assert property (p_one) else $error("runs");
endmodule
`default_nettype wire

// >>> rac_pkg.sv
// shared types of the adapt/lock control
package rac_pkg;

    // one eye measurement from the monitor
    typedef struct packed {
        logic [7:0] width;
        logic [7:0] height;
    } rac_eye_t;

    // equalizer setting: linear boost and feedback taps
    typedef struct packed {
        logic fb_en;
        logic [7:0] boost;
        logic [4:0] tap1;
        logic [3:0] tap2;
        logic [3:0] tap3;
        logic [3:0] tap4;
        logic [3:0] tap5;
    } rac_eq_t;

    // score type selection
    typedef enum logic [1:0] {
        RAC_SC_INVALID,
        RAC_SC_WIDTH,
        RAC_SC_HEIGHT,
        RAC_SC_BOTH
    } rac_score_t;

    // channel control sequence
    typedef enum logic [2:0] {
        RAC_ST_CAL,
        RAC_ST_ACQ,
        RAC_ST_LIN1,
        RAC_ST_FB,
        RAC_ST_LIN2,
        RAC_ST_MLIN,
        RAC_ST_MFB,
        RAC_ST_LOCK
    } rac_state_t;

endpackage

// >>> rac_top.sv
// per-channel adaptation, lock qualification and output control
`timescale 1ns/10ps
`default_nettype none
`include "rac_cfg.svh"

module rac_top
    import rac_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // register access port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // pins: reference clock and divided oscillator
    input wire logic refclk_in,
    input wire logic vco_div_in,
    // recovery and eye monitor
    input wire logic phase_lock_in,
    input wire rac_eye_t eye_in,
    input wire logic eye_valid_in,
    // adaptation engine
    input wire rac_eq_t eng_eq_in,
    input wire logic eng_done_in,
    input wire rac_eq_t host_eq_in,
    output logic lin_run_out,
    output logic fb_run_out,
    output logic [15:0] score_out,
    output logic score_valid_out,
    output rac_eq_t eq_out,
    output logic [3:0] rate_code_out,
    // status
    output logic locked_out,
    output logic lol_irq_out,
    output logic cal_done_out,
    output logic [15:0] vco_coarse_out,
    output logic slow_edge_out,
    // serial data path
    input wire logic [7:0] din_in,
    input wire logic din_valid_in,
    output logic din_ready_out,
    output logic [7:0] dout_out,
    output logic dout_valid_out,
    input wire logic dout_ready_in
);

    // address decode, shared by write and read paths
    function automatic logic [4:0] reg_lookup(input logic [7:0] a);
        logic [4:0] r;
        r = 5'h00;
        unique case (a)
            `RAC_A_SLEW: r = {1'b1, `RAC_I_SLEW};
            `RAC_A_POL: r = {1'b1, `RAC_I_POL};
            `RAC_A_FBTRIG: r = {1'b1, `RAC_I_FBTRIG};
            `RAC_A_FBSCORE: r = {1'b1, `RAC_I_FBSCORE};
            `RAC_A_RATE: r = {1'b1, `RAC_I_RATE};
            `RAC_A_MODE: r = {1'b1, `RAC_I_MODE};
            `RAC_A_LIMA: r = {1'b1, `RAC_I_LIMA};
            `RAC_A_TAPLO: r = {1'b1, `RAC_I_TAPLO};
            `RAC_A_TAPHI: r = {1'b1, `RAC_I_TAPHI};
            `RAC_A_REFMODE: r = {1'b1, `RAC_I_REFMODE};
            `RAC_A_EYEMON: r = {1'b1, `RAC_I_EYEMON};
            `RAC_A_EYETH: r = {1'b1, `RAC_I_EYETH};
            `RAC_A_WA: r = {1'b1, `RAC_I_WA};
            `RAC_A_WB: r = {1'b1, `RAC_I_WB};
            `RAC_A_WC: r = {1'b1, `RAC_I_WC};
            `RAC_A_WEN: r = {1'b1, `RAC_I_WEN};
            default: r = 5'h00;
        endcase
        return r;
    endfunction

    // distance between two frequency counts
    function automatic logic [15:0] abs_diff(input logic [15:0] x, input logic [15:0] y);
        return (x > y) ? (x - y) : (y - x);
    endfunction

    // clamp one tap weight to its limit
    function automatic logic [4:0] tap_clamp(input logic [4:0] w, input logic [4:0] lim);
        return (w > lim) ? lim : w;
    endfunction

    localparam logic [7:0] RST_VALS [16] = '{
        `RAC_R_ZERO, `RAC_R_ZERO, `RAC_R_ZERO, `RAC_R_FBSCORE,
        `RAC_R_ZERO, `RAC_R_MODE, `RAC_R_ZERO, `RAC_R_TAPLO,
        `RAC_R_TAPHI, `RAC_R_REFMODE, `RAC_R_EYEMON, `RAC_R_ZERO,
        `RAC_R_ZERO, `RAC_R_ZERO, `RAC_R_ZERO, `RAC_R_ZERO};

    // ---------------- register file ----------------
    logic [7:0] regs_q [16];
    logic [7:0] regs_d [16];
    logic [7:0] chsel_q, chsel_d;
    logic [7:0] rdata_q, rdata_d;
    logic lin_trig_prev_q, fb_trig_prev_q;
    logic [4:0] wr_hit, rd_hit;
    logic chan_sel;

    // host writes land only in the selected channel's set
    always_comb begin
        wr_hit = reg_lookup(reg_addr_in);
        rd_hit = reg_lookup(reg_addr_in);
        chan_sel = chsel_q[`RAC_CHAN_BIT];
        regs_d = regs_q;
        chsel_d = chsel_q;
        rdata_d = rdata_q;
        if (reg_wr_in && reg_addr_in == `RAC_A_CHSEL) begin
            chsel_d = reg_wdata_in;
        end
        if (reg_wr_in && wr_hit[4] && chan_sel) begin
            regs_d[wr_hit[3:0]] = reg_wdata_in;
        end
        if (reg_rd_in) begin
            if (reg_addr_in == `RAC_A_CHSEL) begin
                rdata_d = chsel_q;
            end else if (rd_hit[4]) begin
                rdata_d = regs_q[rd_hit[3:0]];
            end else begin
                rdata_d = `RAC_R_ZERO;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= RST_VALS[i];
            end
            chsel_q <= `RAC_R_CHSEL;
            rdata_q <= `RAC_R_ZERO;
            lin_trig_prev_q <= 1'b0;
            fb_trig_prev_q <= 1'b0;
        end else begin
            regs_q <= regs_d;
            chsel_q <= chsel_d;
            rdata_q <= rdata_d;
            lin_trig_prev_q <= regs_q[`RAC_I_RATE][`RAC_B_LINTRIG];
            fb_trig_prev_q <= regs_q[`RAC_I_FBTRIG][`RAC_B_FBTRIG];
        end
    end

    // field views
    logic [1:0] mode;
    logic mon_en;
    logic [7:0] th_w, th_h;
    logic lin_trig, fb_trig;
    always_comb begin
        mode = regs_q[`RAC_I_MODE][`RAC_F_MODE];
        mon_en = regs_q[`RAC_I_EYEMON][`RAC_B_MONEN];
        th_w = {regs_q[`RAC_I_EYETH][`RAC_F_TH_W], 4'h0};
        th_h = {regs_q[`RAC_I_EYETH][`RAC_F_TH_H], 4'h0};
        lin_trig = lin_trig_prev_q & ~regs_q[`RAC_I_RATE][`RAC_B_LINTRIG];
        fb_trig = fb_trig_prev_q & ~regs_q[`RAC_I_FBTRIG][`RAC_B_FBTRIG];
    end

    // ---------------- reference clock measurement ----------------
    // pins pass two flops; the third flop only delays for edge detection
    logic ref_s1_q, ref_s2_q, ref_s3_q;
    logic vco_s1_q, vco_s2_q, vco_s3_q;
    logic [7:0] win_q, win_d;
    logic [15:0] vcnt_q, vcnt_d, meas_q, meas_d, cal_q, cal_d;
    logic meas_done_q, meas_done_d, cal_done_q, cal_done_d;
    logic ref_rise, vco_rise;

    // count oscillator edges over a fixed number of reference periods
    always_comb begin
        ref_rise = ref_s2_q & ~ref_s3_q;
        vco_rise = vco_s2_q & ~vco_s3_q;
        win_d = win_q;
        vcnt_d = vco_rise ? vcnt_q + 16'h0001 : vcnt_q;
        meas_d = meas_q;
        meas_done_d = 1'b0;
        cal_d = cal_q;
        cal_done_d = cal_done_q;
        if (ref_rise) begin
            if (win_q == `RAC_REF_WIN - 8'd1) begin
                win_d = 8'h00;
                vcnt_d = 16'h0000;
                meas_d = vcnt_q;
                meas_done_d = 1'b1;
                // first window after reset sets coarse tuning
                if (!cal_done_q) begin
                    cal_d = vcnt_q;
                    cal_done_d = 1'b1;
                end
            end else begin
                win_d = win_q + 8'd1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
            vco_s1_q <= 1'b0;
            vco_s2_q <= 1'b0;
            vco_s3_q <= 1'b0;
            win_q <= 8'h00;
            vcnt_q <= 16'h0000;
            meas_q <= 16'h0000;
            meas_done_q <= 1'b0;
            cal_q <= 16'h0000;
            cal_done_q <= 1'b0;
        end else begin
            ref_s1_q <= refclk_in;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
            vco_s1_q <= vco_div_in;
            vco_s2_q <= vco_s1_q;
            vco_s3_q <= vco_s2_q;
            win_q <= win_d;
            vcnt_q <= vcnt_d;
            meas_q <= meas_d;
            meas_done_q <= meas_done_d;
            cal_q <= cal_d;
            cal_done_q <= cal_done_d;
        end
    end

    // ---------------- lock and adaptation sequence ----------------
    rac_state_t st_q, st_d;
    logic pend_q, pend_d;
    logic [15:0] lock_cnt_q, lock_cnt_d;
    logic lol_q, lol_d;
    logic eye_ok, false_lock, drift;
    logic [15:0] expect_cnt;

    always_comb begin
        // both openings must exceed their thresholds
        eye_ok = (eye_in.width > th_w) && (eye_in.height > th_h);
        // subrate divides the expected oscillator count
        expect_cnt = cal_q >> regs_q[`RAC_I_RATE][`RAC_F_SUBRATE];
        // lock far from calibrated rate is a spur lock
        false_lock = abs_diff(meas_q, expect_cnt) > `RAC_FREQ_TOL;
        // oscillator drift away from locked frequency
        drift = meas_done_q && (abs_diff(meas_q, lock_cnt_q) > `RAC_FREQ_TOL);
        st_d = st_q;
        pend_d = pend_q;
        lock_cnt_d = lock_cnt_q;
        lol_d = 1'b0;
        unique case (st_q)
            RAC_ST_CAL: begin
                if (cal_done_q) begin
                    st_d = RAC_ST_ACQ;
                end
            end
            RAC_ST_ACQ: begin
                // pending adaptation runs before lock is judged
                if (pend_q && mode != 2'b00) begin
                    st_d = RAC_ST_LIN1;
                end else if (lin_trig) begin
                    st_d = RAC_ST_MLIN;
                end else if (fb_trig) begin
                    st_d = RAC_ST_MFB;
                end else if (phase_lock_in && eye_valid_in && eye_ok) begin
                    if (false_lock) begin
                        pend_d = 1'b1;
                    end else begin
                        pend_d = 1'b0;
                        lock_cnt_d = meas_q;
                        st_d = RAC_ST_LOCK;
                    end
                end
            end
            RAC_ST_LIN1: begin
                // mode 3 stops first linear pass at lock
                if (eng_done_in || (mode == 2'b11 && phase_lock_in)) begin
                    st_d = (mode == 2'b01) ? RAC_ST_ACQ : RAC_ST_FB;
                    pend_d = (mode == 2'b01) ? 1'b0 : pend_q;
                end
            end
            RAC_ST_FB: begin
                if (eng_done_in) begin
                    st_d = RAC_ST_LIN2;
                end
            end
            RAC_ST_LIN2: begin
                if (eng_done_in) begin
                    pend_d = 1'b0;
                    st_d = RAC_ST_ACQ;
                end
            end
            RAC_ST_MLIN, RAC_ST_MFB: begin
                // triggers are not looked at while a run is active
                if (eng_done_in) begin
                    st_d = RAC_ST_ACQ;
                end
            end
            RAC_ST_LOCK: begin
                if (lin_trig) begin
                    st_d = RAC_ST_MLIN;
                end else if (fb_trig) begin
                    st_d = RAC_ST_MFB;
                // eye closing or lost phase drops lock
                // eye checks only with monitor enabled
                end else if (drift || !phase_lock_in || (eye_valid_in && mon_en && !eye_ok)) begin
                    lol_d = 1'b1;
                    pend_d = 1'b1;
                    st_d = RAC_ST_ACQ;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= RAC_ST_CAL;
            pend_q <= 1'b1;
            lock_cnt_q <= 16'h0000;
            lol_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pend_q <= pend_d;
            lock_cnt_q <= lock_cnt_d;
            lol_q <= lol_d;
        end
    end

    // ---------------- score and equalizer outputs ----------------
    logic lin_run, fb_run;
    logic [9:0] v_scaled_w;
    logic [7:0] v_scaled, fom_simple;
    logic signed [17:0] dh, dv, fom_weighted;
    rac_score_t sc_type;
    logic use_weighted;
    logic [15:0] score_q, score_d;
    logic score_valid_q, score_valid_d;
    rac_eq_t eq_q, eq_d;

    always_comb begin
        lin_run = (st_q == RAC_ST_LIN1) || (st_q == RAC_ST_LIN2) || (st_q == RAC_ST_MLIN);
        fb_run = (st_q == RAC_ST_FB) || (st_q == RAC_ST_MFB);
        // height scaled to a fixed reference, saturated
        v_scaled_w = ({2'b00, eye_in.height} * `RAC_VSCALE_NUM) >> `RAC_VSCALE_SHIFT;
        v_scaled = (v_scaled_w > 10'd255) ? 8'hff : v_scaled_w[7:0];
        // feedback type, linear type, same encoding
        sc_type = rac_score_t'(fb_run ? regs_q[`RAC_I_FBSCORE][`RAC_F_FBSCORE]
                                      : regs_q[`RAC_I_MODE][`RAC_F_LINSCORE]);
        unique case (sc_type)
            RAC_SC_WIDTH: fom_simple = eye_in.width;
            RAC_SC_HEIGHT: fom_simple = v_scaled;
            RAC_SC_BOTH: fom_simple = (eye_in.width < v_scaled) ? eye_in.width : v_scaled;
            RAC_SC_INVALID: fom_simple = 8'h00;
        endcase
        // weighted score, a taken as a fraction of 256
        dh = $signed({10'h000, eye_in.width}) - $signed({10'h000, regs_q[`RAC_I_WB]});
        dv = $signed({10'h000, eye_in.height}) - $signed({10'h000, regs_q[`RAC_I_WC]});
        fom_weighted = 18'((dh * $signed({10'h000, regs_q[`RAC_I_WA]})
                       + dv * (`RAC_WEIGHT_ONE - $signed({10'h000, regs_q[`RAC_I_WA]}))) >>> `RAC_WEIGHT_SHIFT);
        use_weighted = fb_run ? regs_q[`RAC_I_WEN][`RAC_B_WFB] : regs_q[`RAC_I_WEN][`RAC_B_WLIN];
        score_d = score_q;
        score_valid_d = 1'b0;
        if (eye_valid_in && (lin_run || fb_run)) begin
            score_d = use_weighted ? fom_weighted[15:0] : {8'h00, fom_simple};
            score_valid_d = 1'b1;
        end
        eq_d = eng_eq_in;
        unique case (mode)
            2'b00: eq_d = host_eq_in;
            2'b01: begin
                eq_d.fb_en = 1'b1;
                eq_d.tap1 = 5'h00;
                eq_d.tap2 = 4'h0;
                eq_d.tap3 = 4'h0;
                eq_d.tap4 = 4'h0;
                eq_d.tap5 = 4'h0;
            end
            default: begin
                // taps held within the limit fields
                eq_d.tap1 = tap_clamp(eng_eq_in.tap1, regs_q[`RAC_I_TAPHI][`RAC_F_TAP1MAX]);
                eq_d.tap2 = 4'(tap_clamp({1'b0, eng_eq_in.tap2}, {1'b0, regs_q[`RAC_I_TAPLO][`RAC_F_TAPNMAX]}));
                eq_d.tap3 = 4'(tap_clamp({1'b0, eng_eq_in.tap3}, {1'b0, regs_q[`RAC_I_TAPLO][`RAC_F_TAPNMAX]}));
                eq_d.tap4 = 4'(tap_clamp({1'b0, eng_eq_in.tap4}, {1'b0, regs_q[`RAC_I_TAPLO][`RAC_F_TAPNMAX]}));
                eq_d.tap5 = 4'(tap_clamp({1'b0, eng_eq_in.tap5}, {1'b0, regs_q[`RAC_I_TAPLO][`RAC_F_TAPNMAX]}));
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            score_q <= 16'h0000;
            score_valid_q <= 1'b0;
            eq_q <= '0;
        end else begin
            score_q <= score_d;
            score_valid_q <= score_valid_d;
            eq_q <= eq_d;
        end
    end

    // ---------------- two-entry data buffer ----------------
    // inversion applied on entry so the output is read straight from the two storage flops
    logic [7:0] mem_q [2];
    logic [7:0] mem_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        din_ready_out = (cnt_q != 2'd2);
        dout_valid_out = (cnt_q != 2'd0);
        push = din_valid_in && din_ready_out;
        pop = dout_valid_out && dout_ready_in;
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        if (push) begin
            // polarity inversion of this channel's data
            mem_d[wp_q] = din_in ^ {8{regs_q[`RAC_I_POL][`RAC_B_INV]}};
            wp_d = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // output assignments
    assign dout_out = mem_q[rp_q];
    assign reg_rdata_out = rdata_q;
    assign lin_run_out = lin_run;
    assign fb_run_out = fb_run;
    assign score_out = score_q;
    assign score_valid_out = score_valid_q;
    assign eq_out = eq_q;
    // rate and subrate as one search code
    assign rate_code_out = regs_q[`RAC_I_RATE][`RAC_F_RATE];
    assign locked_out = (st_q == RAC_ST_LOCK);
    assign lol_irq_out = lol_q;
    assign cal_done_out = cal_done_q;
    assign vco_coarse_out = cal_q;
    assign slow_edge_out = regs_q[`RAC_I_SLEW][`RAC_B_SLOW];

endmodule
`default_nettype wire

// >>> tb_retimer_adapt_lock_control.sv
// self-checking bench for the adapt/lock control
`timescale 1ns/10ps
`default_nettype none
module tb_retimer_adapt_lock_control;
    import rac_pkg::*;
    logic mclk_in = '0, rstn_in = '0, reg_wr_in = '0, reg_rd_in = '0, refclk_in = '0, vco_div_in = '0;
    logic phase_lock_in = '0, eye_valid_in = '0, eng_done_in = '0, din_valid_in, dout_ready_in = '0, go = '0;
    logic lin_run_out, fb_run_out, locked_out, lol_irq_out, din_ready_out, dout_valid_out, slow_edge_out, cal_done_out;
    logic [7:0] reg_addr_in = '0, reg_wdata_in = '0, reg_rdata_out, din_in, dout_out, r;
    logic [7:0] ra[8] = '{8'h2c, 8'h31, 8'h34, 8'h35, 8'h36, 8'h3e, 8'h18, 8'h10};
    logic [7:0] rv[8] = '{8'h32, 8'h38, 8'h0f, 8'h1f, 8'h30, 8'h80, 8'h00, 8'h00};
    logic [3:0] rate_code_out;
    rac_eye_t eye_in = '0;
    rac_eq_t eq_out;
    int err_total = 0, n_compared = 0, nirq = 0, nfb = 0, cyc = 0, vp = 20;
    rac_top i_rac_top (.*, .eng_eq_in('1), .host_eq_in('0), .score_out(), .score_valid_out(),
        .vco_coarse_out());
    rac_far_tx i_rac_far_tx (.clk_in(mclk_in), .rstn_in(rstn_in), .go_in(go), .ready_in(din_ready_out),
        .data_out(din_in), .valid_out(din_valid_in));
    // clock, 25 MHz reference, divided oscillator
    initial forever #2.5 mclk_in = ~mclk_in;
    initial forever #20 refclk_in = ~refclk_in;
    initial forever #(vp) vco_div_in = ~vco_div_in;
    // popped words, event counts, hang guard
    always @(posedge mclk_in) begin
        if (dout_valid_out && dout_ready_in) chk(dout_out, i_rac_far_tx.sent_q.pop_front() ^ 8'hff);
        nirq += lol_irq_out;
        nfb += fb_run_out;
        if (++cyc > 30000) begin
            err_total++;
            final_report;
        end
    end
    task automatic chk(input logic [30:0] s, e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one register access, read data lands a cycle later
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge mclk_in) #1 {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = {a, d, w, !w};
        @(posedge mclk_in) #1 {reg_wr_in, reg_rd_in} = '0;
        @(posedge mclk_in) #1 r = reg_rdata_out;
    endtask
    // engine finishes each run; good eyes until lock
    task automatic lock_up;
        for (int k = 0; k < 4000 && !locked_out; k++) begin
            @(posedge mclk_in) #1 eng_done_in = (lin_run_out | fb_run_out) & (k % 8 == 2);
            eye_valid_in = (k % 8 == 0);
            eye_in = {8'($urandom_range(255, 34)), 8'($urandom_range(255, 34))};
        end
        {eye_valid_in, eng_done_in} = '0;
        chk(locked_out, 1);
    endtask
    task automatic low_eye;
        @(posedge mclk_in) #1 {eye_in, eye_valid_in} = {16'h1010, 1'b1};
        @(posedge mclk_in) #1 eye_valid_in = 0;
        repeat (4) @(posedge mclk_in) #1;
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h9107));
        repeat (16) @(posedge mclk_in);
        #1 rstn_in = 1;
        foreach (ra[i]) begin
            bus(0, ra[i], 0);
            chk(r, rv[i]);
        end
        bus(1, 8'h18, 8'h04);
        chk(slow_edge_out, 0);
        bus(1, 8'hff, 8'h01);
        bus(1, 8'h36, 8'h30);
        bus(1, 8'h18, 8'h04);
        chk(slow_edge_out, 1);
        bus(1, 8'h2f, 8'($urandom) & 8'hc0);
        chk(rate_code_out, {reg_wdata_in[7:6], 2'b0});
        // fill with the sink stalled, then drain with random stalls
        bus(1, 8'h1f, 8'h80);
        go = 1;
        repeat (8) @(posedge mclk_in) #1;
        chk(din_ready_out, 0);
        for (int k = 0; k < 60; k++) @(posedge mclk_in) #1 {go, dout_ready_in} = {k < 40, 1'($urandom)};
        dout_ready_in = 1;
        repeat (8) @(posedge mclk_in) #1;
        chk(dout_valid_out, 0);
        bus(1, 8'h6a, 8'h22);
        phase_lock_in = 1;
        lock_up;
        chk({cal_done_out, eq_out}, {10'h3ff, 21'h0});
        low_eye;
        chk({locked_out, 8'(nirq)}, 9'h001);
        lock_up;
        bus(1, 8'h3e, 8'h00);
        low_eye;
        chk(locked_out, 1);
        bus(1, 8'h24, 8'h04);
        bus(1, 8'h24, 8'h00);
        repeat (3) @(posedge mclk_in) #1;
        lock_up;
        chk(nfb > 0, 1);
        vp = 12;
        repeat (1500) @(posedge mclk_in) #1;
        chk(locked_out, 0);
        bus(1, 8'h31, 8'h00);
        chk(eq_out, 0);
        bus(1, 8'h31, 8'h40);
        bus(1, 8'h35, 8'h05);
        chk(eq_out, {9'h1ff, 5'h05, 16'hffff});
        final_report;
    end
endmodule
bind rac_top rac_monitor i_rac_monitor (.*);
`default_nettype wire
